// ===== design/contact_port_snapshot_decoder.sv
// Operation
// [RQ1] Two contact lines X and Y, asserted by pulling them to ground.
// [RQ2] A port style register selects one of five decoding styles.
// [RQ3] Two plus mute: X gives 1, Y gives 2, both mute, open nothing.
// [RQ4] Three snaps: X gives 1, Y gives 2, both give 3, open nothing.
// [RQ5] Four snaps: open 1, X 2, Y 3, both 4.
// [RQ6] Three plus mute: open 1, X 2, Y 3, both mute.
// [RQ7] Event operation recalls the pattern's snapshot on a momentary closure.
// [RQ8] State operation follows the held pattern; party must keep it applied.
// [RQ9] Event operation only in the first two snap styles; others are state.
// [RQ10] Driven port or state-only style beats menu and remote recall.
// [RQ11] While overriding, menu is locked and snapshot number is shown.
// [RQ12] Recall requests come from local menu, remote application and port.
// [RQ13] A recall reloads a component on every input and output channel.
// [RQ14] Recall reloads referenced components, not saved parameter values.
// [RQ15] Style none ignores both lines and makes no recall or mute.
// [RQ16] Each line is synchronised and debounced over programmable cycles.
// [RQ17] Event operation acts once per new non-open pattern, not on open.
`timescale 1ns/1ps
`default_nettype none

module contact_port_snapshot_decoder
    import contact_port_pkg::*;
#(
    parameter int CHANNELS = 8,
    parameter int SNAP_W = 3
) (
    input wire logic core_clk, // System clock, 100 MHz.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic contact_line_x_n, // Contact line X, low when grounded.
    input wire logic contact_line_y_n, // Contact line Y, low when grounded.
    input wire logic local_recall, // Front panel recall strobe.
    input wire logic [SNAP_W-1:0] local_snap, // Front panel snapshot.
    input wire logic hsel, // AHB slave select.
    input wire logic [31:0] haddr, // AHB address.
    input wire logic [1:0] htrans, // AHB transfer type.
    input wire logic hwrite, // AHB write flag.
    input wire logic [2:0] hsize, // AHB transfer size.
    input wire logic [31:0] hwdata, // AHB write data.
    input wire logic hready, // AHB bus ready.
    output logic [31:0] hrdata, // AHB read data.
    output logic hreadyout, // AHB slave ready.
    output logic hresp, // AHB response, always OKAY.
    output logic recall_go, // One-cycle recall pulse.
    output logic [SNAP_W-1:0] recall_snap, // Snapshot being recalled.
    output logic [CHANNELS-1:0] in_load, // Per input component reload.
    output logic [CHANNELS-1:0] out_load, // Per output component reload.
    output logic global_load, // Device-wide settings reload.
    output logic mute, // Output mute level.
    output logic menu_lock, // Snapshot menu locked.
    output logic [SNAP_W-1:0] home_snap // Snapshot on home display.
);

    initial begin
        if (SNAP_W < 3) begin
            $error("Snapshot width must hold the value four.");
        end
        if (CHANNELS < 1) begin
            $error("At least one channel is needed.");
        end
    end

    // ------------------------------------------------------------------
    // Register state.
    // ------------------------------------------------------------------
    port_style_t style;
    logic event_mode;
    logic [DEBOUNCE_W-1:0] settle;
    logic [SNAP_W-1:0] current_snap;
    recall_source_t last_source;
    logic remote_pend;
    logic [SNAP_W-1:0] remote_snap;

    // AHB data phase state.
    logic dp_write;
    logic dp_read;
    logic [7:0] dp_addr;

    // Decoder state.
    logic [1:0] prev_pattern;
    logic gx;
    logic gy;

    // ------------------------------------------------------------------
    // Contact line conditioning.
    // ------------------------------------------------------------------
    // Each ground-active line is synchronised and debounced separately.
    contact_debounce #(
        .CNT_W(DEBOUNCE_W)
    ) u_deb_x (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .line_n(contact_line_x_n), // [RQ1]
        .settle(settle),
        .grounded(gx)
    );

    contact_debounce #(
        .CNT_W(DEBOUNCE_W)
    ) u_deb_y (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .line_n(contact_line_y_n), // [RQ1]
        .settle(settle),
        .grounded(gy)
    );

    // ------------------------------------------------------------------
    // Pattern decoding.
    // ------------------------------------------------------------------
    // Bit 1 is X grounded and bit 0 is Y grounded.
    wire logic [1:0] pattern = {gx, gy};

    // Returns {valid, mute, snapshot} for a style and line pattern.
    function automatic logic [4:0] decode(input port_style_t st,
                                          input logic [1:0] pat);
        logic [4:0] res;
        res = 5'h00;
        case (st)
            STYLE_TWO_MUTE: begin
                case (pat) // [RQ3]
                    2'h2: res = 5'h11;
                    2'h1: res = 5'h12;
                    2'h3: res = 5'h18;
                    default: res = 5'h00;
                endcase
            end
            STYLE_THREE: begin
                case (pat) // [RQ4]
                    2'h2: res = 5'h11;
                    2'h1: res = 5'h12;
                    2'h3: res = 5'h13;
                    default: res = 5'h00;
                endcase
            end
            STYLE_FOUR: begin
                case (pat) // [RQ5]
                    2'h0: res = 5'h11;
                    2'h2: res = 5'h12;
                    2'h1: res = 5'h13;
                    default: res = 5'h14;
                endcase
            end
            STYLE_THREE_MUTE: begin
                case (pat) // [RQ6]
                    2'h0: res = 5'h11;
                    2'h2: res = 5'h12;
                    2'h1: res = 5'h13;
                    default: res = 5'h18;
                endcase
            end
            default: res = 5'h00; // [RQ15]
        endcase
        return res;
    endfunction

    wire logic [4:0] decoded = decode(style, pattern);
    wire logic dec_valid = decoded[4];
    wire logic dec_mute = decoded[3];
    wire logic [SNAP_W-1:0] dec_snap = SNAP_W'(decoded[2:0]);

    // Four snaps and three plus mute permit state operation only.
    wire logic state_only = (style == STYLE_FOUR) ||
        (style == STYLE_THREE_MUTE);
    wire logic use_event = event_mode && !state_only; // [RQ9]
    wire logic port_active = style != STYLE_NONE; // [RQ15]
    wire logic driven = port_active && (pattern != 2'h0);

    // Event mode fires once on each change to a new non-open pattern.
    wire logic event_fire = use_event && dec_valid &&
        (pattern != prev_pattern); // [RQ7] [RQ17]
    // State mode fires when the held pattern selects a new result.
    wire logic state_change = (dec_mute != mute) ||
        (!dec_mute && dec_snap != current_snap);
    wire logic state_fire = port_active && !use_event && dec_valid &&
        state_change; // [RQ8]
    wire logic port_fire = event_fire || state_fire;

    // Port override locks out menu and remote recall.
    wire logic override = driven || (port_active && state_only); // [RQ10]

    // ------------------------------------------------------------------
    // AHB-Lite slave.
    // ------------------------------------------------------------------
    wire logic take = hsel && hready && htrans[1];
    wire logic wr_ctrl = dp_write && dp_addr == ADDR_CONTROL;
    wire logic wr_deb = dp_write && dp_addr == ADDR_DEBOUNCE;
    wire logic wr_recall = dp_write && dp_addr == ADDR_RECALL &&
        hwdata[RECALL_GO_BIT];
    wire logic [2:0] wr_style = hwdata[CTRL_STYLE_LSB +: CTRL_STYLE_W];
    wire logic style_ok = wr_style <= STYLE_THREE_MUTE;

    // Address phase capture; every access completes with no wait state.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dp_write <= 1'b0;
            dp_read <= 1'b0;
            dp_addr <= 8'h00;
        end else begin
            dp_write <= take && hwrite;
            dp_read <= take && !hwrite;
            dp_addr <= haddr[7:0];
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Read data mux for the data phase.
    wire logic [31:0] status_word =
        (32'(current_snap) << STAT_SNAP_LSB) |
        (32'(mute) << STAT_MUTE_BIT) |
        (32'(override) << STAT_OVERRIDE_BIT) |
        (32'(last_source) << STAT_SOURCE_LSB) |
        (32'(pattern) << STAT_PATTERN_LSB);
    wire logic [31:0] ctrl_word = (32'(style) << CTRL_STYLE_LSB) |
        (32'(event_mode) << CTRL_EVENT_BIT);
    wire logic [31:0] read_word =
        (dp_addr == ADDR_CONTROL) ? ctrl_word :
        (dp_addr == ADDR_DEBOUNCE) ? 32'(settle) :
        (dp_addr == ADDR_RECALL) ? 32'(remote_snap) :
        (dp_addr == ADDR_STATUS) ? status_word :
        (dp_addr == ADDR_LINES) ? 32'(pattern) : 32'h0000_0000;

    assign hrdata = dp_read ? read_word : 32'h0000_0000;

    // Configuration registers written by software.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            style <= STYLE_NONE;
            event_mode <= 1'b0;
            settle <= DEBOUNCE_RESET;
        end else begin
            if (wr_ctrl && style_ok) begin
                style <= port_style_t'(wr_style); // [RQ2]
            end
            if (wr_ctrl) begin
                event_mode <= hwdata[CTRL_EVENT_BIT];
            end
            if (wr_deb) begin
                settle <= hwdata[DEBOUNCE_W-1:0]; // [RQ16]
            end
        end
    end

    // Remote request is held until served, refused by the override or displaced by a front panel recall.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            remote_pend <= 1'b0;
            remote_snap <= SNAP_W'(SNAP_RESET);
        end else if (wr_recall) begin
            remote_pend <= 1'b1; // [RQ12]
            remote_snap <= hwdata[RECALL_SNAP_LSB +: SNAP_W];
        end else if (!port_fire) begin
            remote_pend <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Recall arbitration.
    // ------------------------------------------------------------------
    // The port wins, then the front panel, then the remote application.
    wire logic local_ok = local_recall && !override; // [RQ10] [RQ12]
    wire logic remote_ok = remote_pend && !override; // [RQ10]
    wire logic any_recall = (port_fire && !dec_mute) || local_ok ||
        (!port_fire && remote_ok);
    wire logic [SNAP_W-1:0] pick_snap =
        port_fire ? dec_snap : local_ok ? local_snap : remote_snap;
    wire recall_source_t pick_src =
        port_fire ? SRC_PORT : local_ok ? SRC_LOCAL : SRC_REMOTE;

    // Decoder history for event edge detection.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_pattern <= 2'h0;
        end else begin
            prev_pattern <= pattern; // [RQ17]
        end
    end

    // Current snapshot, mute and recall strobes.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            current_snap <= SNAP_W'(SNAP_RESET);
            mute <= 1'b0;
            last_source <= SRC_NONE;
            recall_go <= 1'b0;
            recall_snap <= SNAP_W'(SNAP_RESET);
        end else begin
            recall_go <= 1'b0;
            if (port_fire && dec_mute) begin
                mute <= 1'b1; // [RQ3] [RQ6]
                last_source <= SRC_PORT;
            end else if (any_recall && !(port_fire && dec_mute)) begin
                mute <= 1'b0;
                current_snap <= pick_snap;
                last_source <= pick_src;
                recall_go <= 1'b1; // [RQ12]
                recall_snap <= pick_snap;
            end
        end
    end

    // ------------------------------------------------------------------
    // Component reload and display.
    // ------------------------------------------------------------------
    // A recall reloads the referenced component on every channel and the device-wide settings.
    assign in_load = {CHANNELS{recall_go}}; // [RQ13] [RQ14]
    assign out_load = {CHANNELS{recall_go}}; // [RQ13] [RQ14]
    assign global_load = recall_go; // [RQ13]
    assign menu_lock = override; // [RQ11]
    assign home_snap = override ? current_snap : '0; // [RQ11]

endmodule

`default_nettype wire

// ===== pkg/contact_port_pkg.sv
package contact_port_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses).
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_DEBOUNCE = 8'h04;
    localparam logic [7:0] ADDR_RECALL = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_LINES = 8'h10;

    // ------------------------------------------------------------------
    // Control register fields.
    // ------------------------------------------------------------------
    localparam int CTRL_STYLE_LSB = 0;
    localparam int CTRL_STYLE_W = 3;
    localparam int CTRL_EVENT_BIT = 4;

    // ------------------------------------------------------------------
    // Recall register fields.
    // ------------------------------------------------------------------
    localparam int RECALL_SNAP_LSB = 0;
    localparam int RECALL_SNAP_W = 3;
    localparam int RECALL_GO_BIT = 8;

    // ------------------------------------------------------------------
    // Status register fields.
    // ------------------------------------------------------------------
    localparam int STAT_SNAP_LSB = 0;
    localparam int STAT_MUTE_BIT = 4;
    localparam int STAT_OVERRIDE_BIT = 5;
    localparam int STAT_SOURCE_LSB = 8;
    localparam int STAT_PATTERN_LSB = 12;

    // ------------------------------------------------------------------
    // Reset values and timing.
    // ------------------------------------------------------------------
    localparam int DEBOUNCE_W = 16;
    localparam logic [15:0] DEBOUNCE_RESET = 16'h03E8;
    localparam logic [2:0] SNAP_RESET = 3'h1;

    // Port style encodings as written to the control register.
    typedef enum logic [2:0] {
        STYLE_NONE = 3'h0,
        STYLE_TWO_MUTE = 3'h1,
        STYLE_THREE = 3'h2,
        STYLE_FOUR = 3'h3,
        STYLE_THREE_MUTE = 3'h4
    } port_style_t;

    // Recall source encodings shown in the status register.
    typedef enum logic [1:0] {
        SRC_NONE = 2'h0,
        SRC_LOCAL = 2'h1,
        SRC_REMOTE = 2'h2,
        SRC_PORT = 2'h3
    } recall_source_t;

endpackage

// ===== design/contact_debounce.sv
`timescale 1ns/1ps
`default_nettype none

module contact_debounce
    import contact_port_pkg::*;
#(
    parameter int CNT_W = DEBOUNCE_W
) (
    input wire logic core_clk, // System clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic line_n, // Raw contact line, low when grounded.
    input wire logic [CNT_W-1:0] settle, // Cycles a level must hold.
    output logic grounded // Debounced, high while grounded.
);

    initial begin
        if (CNT_W < 2) begin
            $error("contact_debounce: CNT_W must be at least 2.");
        end
    end

    logic sync_a;
    logic sync_b;
    logic [CNT_W-1:0] count;

    // ------------------------------------------------------------------
    // Synchroniser and settle counter.
    // ------------------------------------------------------------------
    wire logic raw_ground = ~sync_b;
    wire logic differs = raw_ground != grounded;
    wire logic settled = count >= settle;

    // Two flops bring the pin into the clock domain; idle line is open.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_a <= 1'b1;
            sync_b <= 1'b1;
        end else begin
            sync_a <= line_n; // [RQ16]
            sync_b <= sync_a;
        end
    end

    // The new level is accepted once it has held for the settle count.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
            grounded <= 1'b0;
        end else if (!differs) begin
            count <= '0;
        end else if (settled) begin
            count <= '0;
            grounded <= raw_ground; // [RQ16]
        end else begin
            count <= count + 1'b1;
        end
    end

endmodule

`default_nettype wire

// ===== verif/contact_closure_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Contact closures on lines X and Y, with optional chatter.
// ----------------------------------------------------------------------
module contact_closure_model (
    input wire logic core_clk, // Bench clock.
    input wire logic close_x, // Ground line X while high.
    input wire logic close_y, // Ground line Y while high.
    input wire logic bounce, // Chatter on every change while high.
    output logic contact_line_x_n, // Line X, pulled up when open.
    output logic contact_line_y_n // Line Y, pulled up when open.
);
    logic prev_x = 1'b0;
    logic prev_y = 1'b0;
    logic hit_x = 1'b0;
    logic hit_y = 1'b0;
    logic [1:0] chatter = 2'h0;

    // A changed line chatters back to its old level for single cycles.
    always_ff @(posedge core_clk) begin
        prev_x <= close_x;
        prev_y <= close_y;
        if (bounce && (close_x != prev_x || close_y != prev_y)) begin
            chatter <= 2'h3;
            hit_x <= close_x != prev_x;
            hit_y <= close_y != prev_y;
        end else if (chatter != 2'h0) begin
            chatter <= chatter - 2'h1;
        end
    end

    // Grounding needs no voltage; an open line floats to its pull-up.
    assign contact_line_x_n = (chatter[0] && hit_x) ? close_x : !close_x;
    assign contact_line_y_n = (chatter[0] && hit_y) ? close_y : !close_y;
endmodule

`default_nettype wire

// ===== verif/contact_port_snapshot_decoder_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module contact_port_snapshot_decoder_checker #(
    parameter int CHANNELS = 8,
    parameter int SNAP_W = 3
) (
    input wire logic core_clk, // System clock.
    input wire logic rst_n, // Reset, active low.
    input wire logic local_recall, // Front panel strobe.
    input wire logic [SNAP_W-1:0] local_snap, // Front panel snapshot.
    input wire logic hsel, // Bus select.
    input wire logic [1:0] htrans, // Bus transfer type.
    input wire logic hwrite, // Bus write flag.
    input wire logic hready, // Bus ready.
    input wire logic [31:0] hrdata, // Bus read data.
    input wire logic hreadyout, // Slave ready.
    input wire logic hresp, // Slave response.
    input wire logic recall_go, // Recall pulse.
    input wire logic [SNAP_W-1:0] recall_snap, // Recalled snapshot.
    input wire logic [CHANNELS-1:0] in_load, // Input reloads.
    input wire logic [CHANNELS-1:0] out_load, // Output reloads.
    input wire logic global_load, // Device-wide reload.
    input wire logic mute, // Mute level.
    input wire logic menu_lock, // Menu locked.
    input wire logic [SNAP_W-1:0] home_snap // Home display snapshot.
);
    logic rd_phase;

    // Marks the data phase of a read, the only time read data may show.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_phase <= 1'b0;
        end else begin
            rd_phase <= hsel && hready && htrans[1] && !hwrite;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    AST_READY_OKAY: assert property (
        hreadyout && !hresp) else $error("bus stalled or errored");
    AST_HRDATA_IDLE: assert property (
        !rd_phase |-> hrdata == 32'h0) else $error("read data off phase");
    AST_LOAD_ALL: assert property (
        in_load == {CHANNELS{recall_go}} && out_load == {CHANNELS{recall_go}}
        && global_load == recall_go) else $error("reload not on all");
    AST_LOCAL_TAKEN: assert property (
        local_recall && !menu_lock |=> recall_go
        && recall_snap == $past(local_snap)) else $error("local lost");
    AST_SNAP_CAUSE: assert property (
        $changed(recall_snap) |-> recall_go) else $error("silent change");
    AST_MUTE_SILENT: assert property (
        $rose(mute) |-> !recall_go) else $error("mute pulsed recall");
    AST_RECALL_UNMUTES: assert property (
        recall_go |-> !mute) else $error("recall left mute on");
    AST_HOME_BLANK: assert property (
        !menu_lock |-> home_snap == '0) else $error("home shown unlocked");
endmodule

bind contact_port_snapshot_decoder contact_port_snapshot_decoder_checker #(
    .CHANNELS(CHANNELS), .SNAP_W(SNAP_W)) chk_u (
    .core_clk(core_clk), .rst_n(rst_n), .local_recall(local_recall),
    .local_snap(local_snap), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .recall_go(recall_go),
    .recall_snap(recall_snap), .in_load(in_load), .out_load(out_load),
    .global_load(global_load), .mute(mute), .menu_lock(menu_lock),
    .home_snap(home_snap));

`default_nettype wire

// ===== verif/contact_port_snapshot_decoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module contact_port_snapshot_decoder_tb_top
    import contact_port_pkg::*;
;
    logic core_clk, rst_n, close_x, close_y, bounce, local_recall;
    logic hsel, hwrite, hready, hreadyout, hresp, recall_go, global_load;
    logic mute, menu_lock, contact_line_x_n, contact_line_y_n;
    logic [1:0] htrans;
    logic [2:0] hsize, local_snap, recall_snap, home_snap;
    logic [7:0] in_load, out_load;
    logic [16:0] loads;
    logic [31:0] haddr, hwdata, hrdata, d;
    int num_errors, cmp_count, c;

    assign hready = hreadyout;

    contact_closure_model far_u (.core_clk(core_clk), .close_x(close_x),
        .close_y(close_y), .bounce(bounce),
        .contact_line_x_n(contact_line_x_n),
        .contact_line_y_n(contact_line_y_n));

    contact_port_snapshot_decoder #(.CHANNELS(8), .SNAP_W(3)) dut_u (
        .core_clk(core_clk), .rst_n(rst_n),
        .contact_line_x_n(contact_line_x_n),
        .contact_line_y_n(contact_line_y_n), .local_recall(local_recall),
        .local_snap(local_snap), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .recall_go(recall_go), .recall_snap(recall_snap),
        .in_load(in_load), .out_load(out_load), .global_load(global_load),
        .mute(mute), .menu_lock(menu_lock), .home_snap(home_snap));

    // ------------------------------------------------------------------
    // Shared tasks.
    // ------------------------------------------------------------------
    task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One single word transfer: address phase, then data phase.
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge core_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge core_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] unused;
        ahb(1'b1, a, v, unused);
    endtask

    // Counts recall pulses over a window long enough for debouncing.
    task automatic count_go(output int n);
        n = 0;
        repeat (20) begin
            @(negedge core_clk);
            if (recall_go === 1'b1) begin
                n++;
                loads = {global_load, out_load, in_load};
            end
        end
    endtask

    task automatic apply(input logic x, input logic y, input logic b);
        @(posedge core_clk);
        close_x <= x;
        close_y <= y;
        bounce <= b;
        count_go(c);
    endtask

    task automatic local_req(input logic [2:0] s);
        @(posedge core_clk);
        local_recall <= 1'b1;
        local_snap <= s;
        @(posedge core_clk);
        local_recall <= 1'b0;
        count_go(c);
    endtask

    // ------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------
    task automatic t_regs;
        @(negedge core_clk);
        cmp(32'(recall_snap), 32'(SNAP_RESET));
        cmp(32'(menu_lock), 32'h0);
        ahb(1'b0, ADDR_DEBOUNCE, 32'h0, d);
        cmp(d, 32'(DEBOUNCE_RESET));
        wr(ADDR_DEBOUNCE, 32'h2);
        ahb(1'b0, ADDR_DEBOUNCE, 32'h0, d);
        cmp(d, 32'h2);
        wr(ADDR_CONTROL, 32'h17);
        ahb(1'b0, ADDR_CONTROL, 32'h0, d);
        cmp(d, 32'h10);
        ahb(1'b0, 8'h20, 32'h0, d);
        cmp(d, 32'h0);
        wr(ADDR_CONTROL, 32'h0);
    endtask

    task automatic t_none;
        apply(1'b1, 1'b0, 1'b0);
        cmp(32'(c), 32'h0);
        cmp(32'(menu_lock), 32'h0);
        ahb(1'b0, ADDR_LINES, 32'h0, d);
        cmp(d, 32'h2);
        apply(1'b0, 1'b0, 1'b0);
        local_req(3'h2);
        cmp(32'(c), 32'h1);
        cmp(32'(recall_snap), 32'h2);
        cmp(32'(loads), 32'h1FFFF);
        wr(ADDR_RECALL, 32'h104);
        count_go(c);
        cmp(32'(c), 32'h1);
        cmp(32'(recall_snap), 32'h4);
    endtask

    task automatic t_event;
        wr(ADDR_CONTROL, 32'h11);
        apply(1'b1, 1'b0, 1'b0);
        cmp(32'(c), 32'h1);
        cmp(32'(recall_snap), 32'h1);
        cmp(32'(menu_lock), 32'h1);
        cmp(32'(home_snap), 32'h1);
        apply(1'b0, 1'b0, 1'b0);
        cmp(32'(c), 32'h0);
        apply(1'b0, 1'b1, 1'b1);
        cmp(32'(c), 32'h1);
        cmp(32'(recall_snap), 32'h2);
        apply(1'b0, 1'b0, 1'b0);
        apply(1'b1, 1'b1, 1'b0);
        cmp(32'(c), 32'h0);
        cmp(32'(mute), 32'h1);
        local_req(3'h3);
        cmp(32'(c), 32'h0);
        wr(ADDR_RECALL, 32'h103);
        count_go(c);
        cmp(32'(c), 32'h0);
        apply(1'b0, 1'b0, 1'b0);
        cmp(32'(mute), 32'h1);
        apply(1'b1, 1'b0, 1'b0);
        cmp(32'(c), 32'h1);
        cmp(32'(mute), 32'h0);
        apply(1'b0, 1'b0, 1'b0);
    endtask

    // Patterns X, Y, both, open in three snaps, four snaps, three+mute.
    task automatic t_state;
        logic [31:0] ctrl [3];
        logic [2:0] snaps [3][4];
        logic [3:0] mutes [3];
        ctrl = '{32'h02, 32'h13, 32'h14};
        snaps = '{'{3'h1, 3'h2, 3'h3, 3'h3}, '{3'h2, 3'h3, 3'h4, 3'h1},
                  '{3'h2, 3'h3, 3'h3, 3'h1}};
        mutes = '{4'h0, 4'h0, 4'h4};
        for (int s = 0; s < 3; s++) begin
            wr(ADDR_CONTROL, ctrl[s]);
            for (int i = 0; i < 4; i++) begin
                apply(i == 0 || i == 2, i == 1 || i == 2, 1'b0);
                cmp(32'(recall_snap), 32'(snaps[s][i]));
                cmp(32'(mute), 32'(mutes[s][i]));
            end
            cmp(32'(menu_lock), 32'(s != 0));
            wr(ADDR_RECALL, 32'h105);
            count_go(c);
            cmp(32'(c), 32'(s == 0));
        end
    endtask

    // ------------------------------------------------------------------
    // Clock, reset, sequence and watchdog.
    // ------------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        rst_n = 1'b0;
        {close_x, close_y, bounce, local_recall, hsel, hwrite} = 6'h00;
        {local_snap, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        num_errors = 0;
        cmp_count = 0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        t_regs;
        t_none;
        t_event;
        t_state;
        stop_test;
    end

    // Cuts a hang short well beyond the few hundred cycles needed.
    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        stop_test;
    end
endmodule

`default_nettype wire
